// >>> ict_pkg.sv
// Package for isochronous cycle timing: widths, defaults, carrier structs
package ict_pkg;
	// Bit period is 1/12 us at 12 MBaud; time counted in bit ticks
	localparam int unsigned IO_BASE_BITS = 1500;
	localparam int unsigned DP_BASE_BITS = 3000;
	localparam int unsigned ACCEPT_DEFAULT = 4;
	localparam int unsigned CAPTURE_DEFAULT = 2;
	localparam int unsigned EXCHANGE_DEFAULT = 3600;
	localparam int unsigned CYCLE_DEFAULT = 4;
	localparam int unsigned MIN_GAP_SERVO = 1;
	localparam int unsigned VECTOR_UNIT_US = 1000;
	localparam int unsigned BITS_PER_US = 12;
	localparam int unsigned VECTOR_UNIT_BITS = VECTOR_UNIT_US * BITS_PER_US;
	localparam int unsigned WINDOW_DEFAULT = 0;
	localparam int unsigned DEAD_DEFAULT = 0;
	localparam int unsigned CLK_MHZ = 100;
	// Clock cycles per bit tick, rounded down, at least one
	localparam int unsigned BIT_CLKS = (CLK_MHZ / BITS_PER_US) > 0 ? (CLK_MHZ / BITS_PER_US) : 1;
	localparam int unsigned TW = 24;
	localparam int unsigned MW = 8;

	// Configuration carried as one bundle
	typedef struct packed {
		logic vector_mode;
		logic [MW-1:0] bus_cycle_time;
		logic [MW-1:0] setpoint_accept_time;
		logic [MW-1:0] actual_value_capture_time;
		logic [TW-1:0] exchange_duration;
		logic [15:0] sync_window_halfwidth;
		logic [15:0] sync_dead_time;
	} ict_cfg_t;

	// Status bundle
	typedef struct packed {
		logic locked;
		logic cfg_error;
		logic window_miss;
		logic [TW-1:0] cycle_jitter;
	} ict_stat_t;
endpackage : ict_pkg

// >>> ict_bit_tick.sv
// Bit-period tick generator from the system clock
`timescale 1ns/1ps
module ict_bit_tick
	import ict_pkg::*;
#(
	parameter int unsigned DIV = ict_pkg::BIT_CLKS
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic restart,
	output logic tick
);
	logic [7:0] cnt_reg;

	// Free divider, realigned on sync so the bit grid follows the master
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
		end
		else if (restart)
		begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
		end
		else if (cnt_reg == 8'(DIV - 1))
		begin
			cnt_reg <= 8'h00;
			tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule : ict_bit_tick

// >>> ict_cycle_timing.sv
// Isochronous cycle timing for a fieldbus slave drive
`timescale 1ns/1ps
// Overview of operation
// - Hand setpoints to control at acceptance instant
// - Acceptance instant is integer IO-base multiple outside vector mode
// - Acceptance zero means full cycle time
// - Acceptance between exchange plus gap and cycle
// - Vector mode unit is speed-loop period
// - Sync accepted only inside half-width window once aligned; any sync while free-running
// - Dead time delays cycle alignment
// - Broadcast marks each cycle; jitter is lateness
// - Capture actual value before each cycle start
module ict_cycle_timing
	import ict_pkg::*;
#(
	parameter int unsigned IO_BASE = ict_pkg::IO_BASE_BITS,
	parameter int unsigned DP_BASE = ict_pkg::DP_BASE_BITS,
	parameter int unsigned VEC_UNIT = ict_pkg::VECTOR_UNIT_BITS,
	parameter int unsigned DIV = ict_pkg::BIT_CLKS
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire ict_pkg::ict_cfg_t cfg,
	input wire logic global_control_broadcast,
	input wire logic [31:0] setpoint_in,
	input wire logic [31:0] position_in,
	output ict_pkg::ict_stat_t status,
	output logic [31:0] setpoint_out,
	output logic setpoint_strobe,
	output logic [31:0] position_out,
	output logic capture_strobe,
	output logic cycle_start
);
	import ict_pkg::*;

	typedef enum logic [1:0] {ST_FREE, ST_DEAD, ST_RUN} ict_state_t;

	ict_state_t state_reg;
	logic tick;
	logic [TW-1:0] bit_cnt_reg;
	logic [TW-1:0] dead_cnt_reg;
	logic [TW-1:0] cycle_bits;
	logic [TW-1:0] accept_bits;
	logic [TW-1:0] capture_bits;
	logic [TW-1:0] capture_at;
	logic [TW-1:0] min_accept_bits;
	logic [TW-1:0] unit_bits;
	logic [TW-1:0] win;
	logic in_window;
	logic gc_accept;
	logic restart;
	logic [31:0] setpoint_hold_reg;

	// Multiplies a count of units into bit periods, saturating
	function automatic logic [TW-1:0] to_bits(input logic [MW-1:0] n, input logic [TW-1:0] u);
		logic [TW+MW-1:0] p;
		p = (TW+MW)'(n) * (TW+MW)'(u);
		to_bits = (p > (TW+MW)'({TW{1'b1}})) ? {TW{1'b1}} : p[TW-1:0];
	endfunction : to_bits

	// Vector mode steps in speed-loop periods instead of IO base
	assign unit_bits = cfg.vector_mode ? TW'(VEC_UNIT) : TW'(IO_BASE);
	assign cycle_bits = to_bits(cfg.bus_cycle_time, TW'(DP_BASE));
	// Zero acceptance setting folds onto the cycle boundary
	assign accept_bits = (cfg.setpoint_accept_time == '0) ? cycle_bits
		: to_bits(cfg.setpoint_accept_time, unit_bits);
	assign capture_bits = (cfg.actual_value_capture_time == '0) ? cycle_bits
		: to_bits(cfg.actual_value_capture_time, TW'(IO_BASE));
	// Strobe registers one count later, so aim one count early; full cycle means the boundary
	assign capture_at = (capture_bits >= cycle_bits) ? cycle_bits - TW'(1)
		: cycle_bits - capture_bits - TW'(1);
	assign min_accept_bits = cfg.exchange_duration + to_bits(MW'(MIN_GAP_SERVO), unit_bits);
	assign win = TW'(cfg.sync_window_halfwidth);

	// Window around the expected cycle boundary; free-running accepts any
	assign in_window = (state_reg == ST_FREE)
		|| (bit_cnt_reg <= win)
		|| (bit_cnt_reg + win >= cycle_bits - TW'(1));
	assign gc_accept = global_control_broadcast && in_window;
	assign restart = (state_reg == ST_DEAD) && tick && (dead_cnt_reg == '0);

	ict_bit_tick #(
		.DIV(DIV)
	) u_tick (
		.clk(clk),
		.rst_b(rst_b),
		.restart(gc_accept),
		.tick(tick)
	);

	// Alignment state: a good broadcast waits out the dead time, then runs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= ST_FREE;
			dead_cnt_reg <= '0;
		end
		else if (gc_accept)
		begin
			state_reg <= ST_DEAD;
			dead_cnt_reg <= TW'(cfg.sync_dead_time);
		end
		else
		begin
			unique case (state_reg)
				ST_FREE: state_reg <= ST_FREE;
				ST_DEAD:
				begin
					if (tick)
					begin
						if (dead_cnt_reg == '0)
							state_reg <= ST_RUN;
						else
							dead_cnt_reg <= dead_cnt_reg - TW'(1);
					end
				end
				ST_RUN: state_reg <= ST_RUN;
			endcase
		end
	end

	// Local cycle counter in bit periods, restarted by the aligned sync
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			bit_cnt_reg <= '0;
		else if (restart)
			bit_cnt_reg <= '0;
		else if (tick && state_reg == ST_RUN)
		begin
			if (bit_cnt_reg >= cycle_bits - TW'(1))
				bit_cnt_reg <= '0; // Flywheel when a broadcast is missed
			else
				bit_cnt_reg <= bit_cnt_reg + TW'(1);
		end
	end

	// Strobes derived from the counter, one clock each
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cycle_start <= 1'b0;
			setpoint_strobe <= 1'b0;
			capture_strobe <= 1'b0;
		end
		else
		begin
			cycle_start <= restart || (tick && state_reg == ST_RUN
				&& bit_cnt_reg >= cycle_bits - TW'(1));
			setpoint_strobe <= tick && state_reg == ST_RUN
				&& bit_cnt_reg == accept_bits - TW'(1);
			// Capture sits capture_bits before the next cycle start
			capture_strobe <= tick && state_reg == ST_RUN
				&& bit_cnt_reg == capture_at;
		end
	end

	// Latest received setpoint held, then released at the acceptance instant
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			setpoint_hold_reg <= 32'h00000000;
			setpoint_out <= 32'h00000000;
		end
		else
		begin
			setpoint_hold_reg <= setpoint_in;
			if (tick && state_reg == ST_RUN && bit_cnt_reg == accept_bits - TW'(1))
				setpoint_out <= setpoint_hold_reg;
		end
	end

	// Position value latched at the capture instant
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			position_out <= 32'h00000000;
		else if (tick && state_reg == ST_RUN && bit_cnt_reg == capture_at)
			position_out <= position_in;
	end

	// Status: lock, misconfiguration, rejected broadcasts and jitter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status <= '0;
		else
		begin
			status.locked <= (state_reg == ST_RUN);
			// Acceptance must lie after exchange plus gap, not past cycle
			status.cfg_error <= (accept_bits < min_accept_bits)
				|| (accept_bits > cycle_bits)
				|| (cfg.exchange_duration >= cycle_bits);
			if (global_control_broadcast && !in_window)
				status.window_miss <= 1'b1;
			else if (gc_accept)
				status.window_miss <= 1'b0;
			// Lateness measured at each accepted broadcast while running; an early one records zero
			if (gc_accept && state_reg == ST_RUN)
				status.cycle_jitter <= (bit_cnt_reg <= win) ? bit_cnt_reg : '0;
		end
	end
endmodule : ict_cycle_timing

// >>> ict_cycle_monitor.sv
// Checker of strobe timing, data hand-over and config check
`timescale 1ns/1ps
module ict_cycle_monitor
	import ict_pkg::*;
#(
	parameter int unsigned IO_BASE = ict_pkg::IO_BASE_BITS,
	parameter int unsigned DP_BASE = ict_pkg::DP_BASE_BITS,
	parameter int unsigned VEC_UNIT = ict_pkg::VECTOR_UNIT_BITS,
	parameter int unsigned DIV = ict_pkg::BIT_CLKS
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire ict_pkg::ict_cfg_t cfg,
	input wire logic global_control_broadcast,
	input wire logic [31:0] setpoint_in,
	input wire logic [31:0] position_in,
	input wire ict_pkg::ict_stat_t status,
	input wire logic [31:0] setpoint_out,
	input wire logic setpoint_strobe,
	input wire logic [31:0] position_out,
	input wire logic capture_strobe,
	input wire logic cycle_start
);
	logic [31:0] cnt_reg;
	logic [31:0] age, cyc, unit, acc, cap, xch;
	logic bad;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Times in bits; a zero acceptance or capture setting stands for a whole cycle
	assign cyc = 32'(cfg.bus_cycle_time) * DP_BASE;
	assign unit = cfg.vector_mode ? VEC_UNIT : IO_BASE;
	assign acc = (cfg.setpoint_accept_time == 8'h00) ? cyc : 32'(cfg.setpoint_accept_time) * unit;
	assign cap = (cfg.actual_value_capture_time == 8'h00) ? cyc
		: 32'(cfg.actual_value_capture_time) * IO_BASE;
	assign xch = 32'(cfg.exchange_duration);
	assign bad = (acc < xch + unit) || (acc > cyc) || (xch >= cyc);
	assign age = cycle_start ? 32'h0 : cnt_reg;
	// Clocks since the last cycle start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= age + 32'h1;
	end
	AST_SP_PULSE: assert property (setpoint_strobe |=> !setpoint_strobe)
		else $error("setpoint strobe too long");
	AST_CAP_PULSE: assert property (capture_strobe |=> !capture_strobe)
		else $error("capture strobe too long");
	AST_CS_PULSE: assert property (cycle_start |=> !cycle_start)
		else $error("cycle start too long");
	AST_SP_DATA: assert property ($changed(setpoint_out) |-> setpoint_strobe)
		else $error("setpoint changed off strobe");
	AST_POS_DATA: assert property ($changed(position_out) |-> capture_strobe)
		else $error("position changed off strobe");
	// Full count since the last start, so a boundary strobe sees the whole cycle
	AST_SP_TIME: assert property (setpoint_strobe && !status.cfg_error |-> cnt_reg == acc * DIV)
		else $error("setpoint strobe mistimed");
	AST_CAP_TIME: assert property (capture_strobe && !status.cfg_error |-> age == (cyc - cap) * DIV)
		else $error("capture strobe mistimed");
	// Flag is registered, so it is judged one clock after a settled config
	AST_CFG_ERR: assert property ($stable(cfg) [*3] |=> status.cfg_error == bad)
		else $error("config error flag wrong");
endmodule : ict_cycle_monitor
bind ict_cycle_timing ict_cycle_monitor #(.IO_BASE(IO_BASE), .DP_BASE(DP_BASE),
	.VEC_UNIT(VEC_UNIT), .DIV(DIV)) u_mon (.clk(clk), .rst_b(rst_b), .cfg(cfg),
	.global_control_broadcast(global_control_broadcast), .setpoint_in(setpoint_in),
	.position_in(position_in), .status(status), .setpoint_out(setpoint_out),
	.setpoint_strobe(setpoint_strobe), .position_out(position_out),
	.capture_strobe(capture_strobe), .cycle_start(cycle_start));

// >>> ict_master_model.sv
// Bus master stand-in issuing the cycle-marking broadcast
`timescale 1ns/1ps
module ict_master_model
#(
	parameter int unsigned PERIOD = 32,
	parameter int unsigned EXCHANGE_DURATION = 8,
	parameter int unsigned TOKEN_HOLD_TIME = 16,
	parameter int unsigned PROBE_EVERY = 4,
	parameter int unsigned MASTER_CONTROL_OFFSET = 4
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] late,
	output logic global_control_broadcast
);
	int unsigned phase;
	int unsigned cycle_no;
	logic acyclic_service_slot;
	logic reserve_pause;
	logic new_node_probe_slot;
	logic control_start;
	// Nominal grid keeps running, so a late setting shifts pulses on it
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase <= 0;
			cycle_no <= 0;
			acyclic_service_slot <= 1'b0;
			reserve_pause <= 1'b0;
			new_node_probe_slot <= 1'b0;
			control_start <= 1'b0;
			global_control_broadcast <= 1'b0;
		end
		else
		begin
			phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
			cycle_no <= (phase == PERIOD - 1) ? cycle_no + 1 : cycle_no;
			// Acyclic traffic only while the token hold time has not run out
			acyclic_service_slot <= (phase >= EXCHANGE_DURATION)
				&& (phase < TOKEN_HOLD_TIME);
			reserve_pause <= (phase >= TOKEN_HOLD_TIME);
			new_node_probe_slot <= (cycle_no % PROBE_EVERY == 0) && (phase == PERIOD - 2);
			control_start <= (phase == MASTER_CONTROL_OFFSET);
			global_control_broadcast <= (phase == 32'(late));
		end
	end
endmodule : ict_master_model

// >>> tb_ict_cycle_timing.sv
// Self-checking bench for the cycle timing block
`timescale 1ns/1ps
module tb_ict_cycle_timing;
	import ict_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] late = 8'h00;
	ict_cfg_t cfg = '0;
	logic gc, sp_stb, cap_stb, cs;
	logic [31:0] sp_in = 32'h0;
	logic [31:0] pos_in = 32'h0;
	logic [31:0] sp_out, pos_out;
	ict_stat_t status;
	int errors = 0;
	int cmp_count = 0;
	int ticks = 0;
	int k, n, eff;
	int tv[8] = '{0, 0, 0, 0, 0, 1, 1, 1};
	int ta[8] = '{4, 0, 3, 9, 1, 2, 1, 5};
	int te[8] = '{0, 0, 0, 1, 1, 0, 1, 1};
	always #5 clk = ~clk;
	ict_cycle_timing #(.IO_BASE(4), .DP_BASE(8), .VEC_UNIT(8), .DIV(1)) DUT (.clk(clk),
		.rst_b(rst_b), .cfg(cfg), .global_control_broadcast(gc), .setpoint_in(sp_in),
		.position_in(pos_in), .status(status), .setpoint_out(sp_out),
		.setpoint_strobe(sp_stb), .position_out(pos_out), .capture_strobe(cap_stb),
		.cycle_start(cs));
	ict_master_model #(.PERIOD(32)) u_master (.clk(clk), .rst_b(rst_b), .late(late),
		.global_control_broadcast(gc));
	task automatic print_verdict();
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// Hang guard, well above the several hundred clocks the run needs
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// Config is only changed under reset so no cycle sees a mix
	task automatic restart(input logic v, input int a, input int w, input int d);
		@(negedge clk);
		rst_b = 1'b0;
		late = 8'h00;
		cfg = '{v, 8'h04, 8'(a), 8'h02, 24'h000008, 16'(w), 16'(d)};
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
	endtask : restart
	// Index 0 setpoint, 1 capture, 2 cycle start, 3 broadcast
	task automatic wait_for(input int w, output int c);
		logic [3:0] s;
		for (c = 1; c < 200; c++)
		begin
			@(posedge clk);
			#1;
			s = {gc, cs, cap_stb, sp_stb};
			if (s[w] === 1'b1)
				break;
		end
	endtask : wait_for
	initial
	begin
		for (n = 0; n < 8; n++)
		begin
			restart(tv[n][0], ta[n], 0, 0);
			chk({31'h0, status.locked}, 32'h0);
			sp_in = 32'hA5C3F000 + 32'(n);
			wait_for(2, k);
			if (te[n] == 0)
			begin
				wait_for(0, k);
				eff = (ta[n] == 0) ? 32 : ta[n] * (tv[n] ? 8 : 4);
				chk(32'(k), 32'(eff));
				chk(sp_out, sp_in);
				chk({31'h0, status.locked}, 32'h1);
			end
			chk({31'h0, status.cfg_error}, 32'(te[n]));
		end
		restart(1'b0, 4, 0, 0);
		pos_in = 32'h5A3C1E0F;
		wait_for(2, k);
		wait_for(1, k);
		chk(32'(k), 32'h18);
		chk(pos_out, pos_in);
		wait_for(2, k);
		chk(32'(k), 32'h8);
		for (n = 0; n < 6; n += 5)
		begin
			restart(1'b0, 4, 0, n);
			wait_for(3, k);
			wait_for(2, k);
			chk(32'(k), 32'(n + 3));
		end
		for (n = 0; n < 8; n += 4)
		begin
			restart(1'b0, 4, n, 0);
			wait_for(2, k);
			repeat (10) @(negedge clk);
			late = 8'h03;
			repeat (70) @(negedge clk);
			chk({31'h0, status.window_miss}, 32'(n == 0));
		end
		// Broadcast five late; counter reads five less the three-count sync lag
		restart(1'b0, 4, 8, 0);
		wait_for(2, k);
		@(negedge clk);
		late = 8'h05;
		wait_for(3, k);
		repeat (2) @(negedge clk);
		chk(32'(status.cycle_jitter), 32'h2);
		chk({31'h0, status.window_miss}, 32'h0);
		print_verdict();
	end
endmodule : tb_ict_cycle_timing
